/* tb/test_wake_watchdog_comparator_regs.sv */
// Self-checking bench for the wake/watchdog and comparator register pair.
// Assumes wwc_regs with a short oscillator stabilisation count of 2 ticks.
`timescale 1ns/100ps
`default_nettype none
module test_wake_watchdog_comparator_regs;
  import wwc_pkg::*;
  logic mclk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic [5:0] io_addr_in = 6'h00;
  logic io_wr_in = 1'b0;
  logic io_rd_in = 1'b0;
  logic [7:0] io_wdata_in = 8'h00;
  logic low_speed_internal_osc_in = 1'b0;
  logic timer_two_clock_in = 1'b0;
  logic cmp_raw_in = 1'b0;
  logic external_oscillator_en_in = 1'b0;
  logic wake_request_in = 1'b0;
  logic wake_from_system_stop_in = 1'b0;
  logic [7:0] io_rdata_out;
  logic [18:0] wdt_period_out;
  logic [2:0] cmp_minus_sel_out;
  logic wake_busy_out, wake_done_out, lvr_enable_out, cmp_enable_out;
  logic cmp_minus_reserved_out, cmp_plus_sel_out, cmp_result_out;
  logic [7:0] q;
  int n_errors = 0;
  int n_compared = 0;
  wwc_regs #(.OSC_STABLE_TICKS(12'h002)) DUT (.*);
  initial begin
    forever #2.5 mclk_in = ~mclk_in;
  end
  task complete_run;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task check(input logic [18:0] seen, input logic [18:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(negedge mclk_in);
  endtask
  task wr(input logic [5:0] a, input logic [7:0] d);
    io_addr_in = a;
    io_wdata_in = d;
    io_wr_in = 1'b1;
    cyc(1);
    io_wr_in = 1'b0;
  endtask
  task rd(input logic [5:0] a);
    io_addr_in = a;
    io_rd_in = 1'b1;
    cyc(1);
    q = io_rdata_out;
    io_rd_in = 1'b0;
  endtask
  task t_misc;
    logic [18:0] tab [4] = '{19'h02000, 19'h04000, 19'h10000, 19'h40000};
    for (int s = 0; s < 4; s++) begin
      wr(WWC_ADDR_WAKE_WDT, {5'h00, s[0], s[1:0]});
      check(lvr_enable_out, !s[0]);
      cyc(1);
      check(wdt_period_out, tab[s]);
      rd(WWC_ADDR_WAKE_WDT);
      check(q, 8'h00);
    end
    wr(6'h19, 8'hff);
    rd(6'h19);
    check({q, cmp_enable_out}, 9'h000);
  endtask
  task t_sel;
    for (int m = 0; m < 8; m++) begin
      wr(WWC_ADDR_CMP_CTRL, {2'h1, 2'h0, m[2:0], m[0]});
      check({cmp_minus_sel_out, cmp_minus_reserved_out}, {m[2:0], m >= 6});
      check(cmp_plus_sel_out, m[0]);
      rd(WWC_ADDR_CMP_CTRL);
      check(q, {4'h0, m[2:0], m[0]});
    end
  endtask
  task t_out;
    cmp_raw_in = 1'b1;
    wr(WWC_ADDR_CMP_CTRL, 8'h80);
    cyc(6);
    rd(WWC_ADDR_CMP_CTRL);
    check({q, cmp_result_out}, {8'hc0, 1'b1});
    wr(WWC_ADDR_CMP_CTRL, 8'h90);
    cyc(3);
    check(cmp_result_out, 1'b0);
    cmp_raw_in = 1'b0;
    cyc(6);
    rd(WWC_ADDR_CMP_CTRL);
    check({q, cmp_result_out}, {8'h90, 1'b1});
    cmp_raw_in = 1'b1;
    wr(WWC_ADDR_CMP_CTRL, 8'h00);
    cyc(3);
    check(cmp_result_out, 1'b0);
    cmp_raw_in = 1'b0;
  endtask
  task tclk;
    timer_two_clock_in = 1'b1;
    cyc(4);
    timer_two_clock_in = 1'b0;
    cyc(4);
  endtask
  task t_sample;
    wr(WWC_ADDR_CMP_CTRL, 8'ha0);
    tclk;
    cmp_raw_in = 1'b1;
    cyc(8);
    check(cmp_result_out, 1'b0);
    tclk;
    check(cmp_result_out, 1'b1);
    wr(WWC_ADDR_CMP_CTRL, 8'hb0);
    cyc(6);
    check(cmp_result_out, 1'b1);
    tclk;
    check(cmp_result_out, 1'b0);
  endtask
  // Ticks are 8 mclk long so the done pulse lands inside the tick that ends the count
  task t_wake(input logic [7:0] cfg, input logic ext, input logic sys, input int n);
    int k;
    logic seen;
    wr(WWC_ADDR_WAKE_WDT, cfg);
    external_oscillator_en_in = ext;
    wake_from_system_stop_in = sys;
    wake_request_in = 1'b1;
    cyc(1);
    wake_request_in = 1'b0;
    check(wake_busy_out, 1'b1);
    k = 0;
    seen = 1'b0;
    while (!seen && k < n + 4) begin
      k++;
      for (int i = 0; i < 8; i++) begin
        low_speed_internal_osc_in = (i < 4);
        cyc(1);
        if (wake_done_out === 1'b1) seen = 1'b1;
      end
    end
    if (!seen) begin
      n_errors++;
      $display("unexpected at %0t: wake never completed", $time);
    end
    check(k[18:0], n[18:0]);
    check(wake_busy_out, 1'b0);
  endtask
  initial begin
    cyc(8);
    reset_n_in = 1'b1;
    check(lvr_enable_out, 1'b1);
    check(wdt_period_out, WWC_WDT_PERIOD_8K);
    t_misc;
    t_sel;
    t_out;
    t_sample;
    t_wake(8'h00, 1'b0, 1'b0, 3000);
    t_wake(8'h20, 1'b0, 1'b0, 45);
    t_wake(8'h20, 1'b0, 1'b1, 47);
    t_wake(8'h20, 1'b1, 1'b1, 3000);
    complete_run;
  end
endmodule
`default_nettype wire

/* tb/wwc_regs_assertions.sv */
// Checker for the wake/watchdog and comparator register pair.
// Assumes it is bound to wwc_regs and sees only that module's ports.
`timescale 1ns/100ps
`default_nettype none
module wwc_regs_assertions
  import wwc_pkg::*;
(
  input wire logic mclk_in,
  input wire logic reset_n_in,
  input wire logic [5:0] io_addr_in,
  input wire logic io_wr_in,
  input wire logic io_rd_in,
  input wire logic [7:0] io_wdata_in,
  input wire logic [7:0] io_rdata_out,
  input wire logic wake_request_in,
  input wire logic wake_busy_out,
  input wire logic wake_done_out,
  input wire logic lvr_enable_out,
  input wire logic [18:0] wdt_period_out,
  input wire logic cmp_enable_out,
  input wire logic [2:0] cmp_minus_sel_out,
  input wire logic cmp_minus_reserved_out,
  input wire logic cmp_plus_sel_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!reset_n_in);
  wire logic wr17 = io_wr_in && io_addr_in == WWC_ADDR_WAKE_WDT;
  wire logic wr18 = io_wr_in && io_addr_in == WWC_ADDR_CMP_CTRL;
  wire logic rd17 = io_rd_in && io_addr_in == WWC_ADDR_WAKE_WDT;
  wire logic rd18 = io_rd_in && io_addr_in == WWC_ADDR_CMP_CTRL;
  function automatic logic [18:0] period_of(input logic [1:0] s);
    return s == 2'h0 ? 19'h02000 : s == 2'h1 ? 19'h04000 : s == 2'h2 ? 19'h10000 : 19'h40000;
  endfunction
  AST_LVR: assert property (wr17 |=> lvr_enable_out == !$past(io_wdata_in[2]))
    else $error("low-voltage reset enable wrong after write");
  AST_WDT: assert property (wr17 |-> ##2 wdt_period_out == period_of($past(io_wdata_in[1:0], 2)))
    else $error("watchdog period wrong after write");
  AST_RD17: assert property (rd17 |=> io_rdata_out == 8'h00)
    else $error("write-only register read back nonzero");
  AST_EN: assert property (wr18 |=> cmp_enable_out == $past(io_wdata_in[7]))
    else $error("comparator enable wrong after write");
  AST_SEL: assert property (wr18 |=> {cmp_minus_sel_out, cmp_plus_sel_out} == $past(io_wdata_in[3:0]))
    else $error("input selection wrong after write");
  AST_RSV: assert property (cmp_minus_reserved_out == (cmp_minus_sel_out[2:1] == 2'h3))
    else $error("reserved minus flag wrong");
  AST_RD18: assert property (rd18 |=> io_rdata_out[7] == $past(cmp_enable_out) && (!io_rdata_out[6] || $past(cmp_enable_out)))
    else $error("comparator control read wrong");
  AST_DONE: assert property (wake_done_out |-> wake_busy_out ##1 !wake_busy_out && !wake_done_out)
    else $error("wake done pulse malformed");
  AST_BUSY: assert property ($rose(wake_busy_out) |-> $past(wake_request_in))
    else $error("wake busy rose without request");
endmodule
bind wwc_regs wwc_regs_assertions u_chk (.*);
`default_nettype wire

/* verilog/wwc_pkg.sv */
// Constants, field layouts and types for the wake/watchdog and comparator register pair.
// Assumes an 8-bit IO-space register port with 6-bit addresses.
package wwc_pkg;

  // IO addresses
  localparam logic [5:0] WWC_ADDR_WAKE_WDT = 6'h17;
  localparam logic [5:0] WWC_ADDR_CMP_CTRL = 6'h18;

  // wake_watchdog_config fields
  localparam int WWC_FAST_WAKE_BIT = 5;
  localparam int WWC_LVR_DIS_BIT = 2;
  localparam int WWC_WDT_SEL_MSB = 1;
  localparam int WWC_WDT_SEL_LSB = 0;

  // comparator_control fields
  localparam int WWC_CMP_EN_BIT = 7;
  localparam int WWC_CMP_RES_BIT = 6;
  localparam int WWC_CMP_SAMPLE_BIT = 5;
  localparam int WWC_CMP_INV_BIT = 4;
  localparam int WWC_CMP_MINUS_MSB = 3;
  localparam int WWC_CMP_MINUS_LSB = 1;
  localparam int WWC_CMP_PLUS_BIT = 0;

  localparam logic [7:0] WWC_REG_RESET = 8'h00;
  localparam logic [7:0] WWC_READ_NONE = 8'h00;

  // Wake-up lengths in low-speed oscillator clocks
  localparam logic [11:0] WWC_WAKE_NORMAL_TICKS = 12'hbb8;
  localparam logic [11:0] WWC_WAKE_FAST_TICKS = 12'h02d;
  localparam logic [11:0] WWC_TICK_ONE = 12'h001;
  localparam logic [11:0] WWC_TICK_ZERO = 12'h000;

  // Watchdog timeout in low-speed oscillator periods
  localparam logic [1:0] WWC_WDT_8K = 2'h0;
  localparam logic [1:0] WWC_WDT_16K = 2'h1;
  localparam logic [1:0] WWC_WDT_64K = 2'h2;
  localparam logic [1:0] WWC_WDT_256K = 2'h3;
  localparam logic [18:0] WWC_WDT_PERIOD_8K = 19'h02000;
  localparam logic [18:0] WWC_WDT_PERIOD_16K = 19'h04000;
  localparam logic [18:0] WWC_WDT_PERIOD_64K = 19'h10000;
  localparam logic [18:0] WWC_WDT_PERIOD_256K = 19'h40000;

  // Minus input selections
  localparam logic [2:0] WWC_MINUS_PORT_A_PIN_THREE = 3'h0;
  localparam logic [2:0] WWC_MINUS_PORT_A_PIN_FOUR = 3'h1;
  localparam logic [2:0] WWC_MINUS_BANDGAP = 3'h2;
  localparam logic [2:0] WWC_MINUS_RES_LADDER = 3'h3;
  localparam logic [2:0] WWC_MINUS_PORT_B_PIN_SIX = 3'h4;
  localparam logic [2:0] WWC_MINUS_PORT_B_PIN_SEVEN = 3'h5;
  localparam logic [1:0] WWC_MINUS_RESERVED_TOP = 2'h3;

  typedef enum logic [1:0] {
    WWC_WAKE_IDLE = 2'b00,
    WWC_WAKE_COUNT = 2'b01,
    WWC_WAKE_STAB = 2'b11,
    WWC_WAKE_DONE = 2'b10
  } wwc_wake_state_e;

  typedef struct packed {
    logic fast_wake;
    logic lvr_disable;
    logic [1:0] wdt_sel;
  } wwc_wake_cfg_s;

  typedef struct packed {
    logic enable;
    logic sample;
    logic invert;
    logic [2:0] minus_sel;
    logic plus_sel;
  } wwc_cmp_cfg_s;

endpackage

/* verilog/wwc_regs.sv */
// Wake-up/watchdog configuration and comparator control registers with wake timing.
// Assumes a synchronous IO-space port; oscillator, timer-2 clock and comparator
// result arrive asynchronously and are synchronised here.
`timescale 1ns/100ps
`default_nettype none
// Operation
// - Normal wake takes 3000 low-speed clocks; fast takes 45 plus stabilisation.
// - With external oscillator enabled, normal wake timing applies regardless of fast bit.
// - Fast wake adds stabilisation only after system-stop, none after execution-stop.
// - Wake/watchdog bit 2 set disables low-voltage reset; clear keeps it enabled.
// - Bits 1-0 pick watchdog timeout of 8k, 16k, 64k or 256k periods.
// - Comparator control bit 7 turns comparator on; software disables digital inputs.
// - Read-only bit 6 reports one when plus input exceeds minus input.
// - Bit 5 set samples result output on timer-2 clock; clear passes it directly.
// - Bit 4 set inverts the comparator result output.
// - Bits 3-1 select minus input; codes 11X are reserved.
// - Bit 0 selects plus input: ladder when 0, port-A pin when 1.
module wwc_regs
  import wwc_pkg::*;
#(
  parameter logic [11:0] OSC_STABLE_TICKS = 12'h020
) (
  input wire logic mclk_in,
  input wire logic reset_n_in,
  input wire logic [5:0] io_addr_in,
  input wire logic io_wr_in,
  input wire logic io_rd_in,
  input wire logic [7:0] io_wdata_in,
  output logic [7:0] io_rdata_out,
  input wire logic low_speed_internal_osc_in,
  input wire logic timer_two_clock_in,
  input wire logic cmp_raw_in,
  input wire logic external_oscillator_en_in,
  input wire logic wake_request_in,
  input wire logic wake_from_system_stop_in,
  output logic wake_busy_out,
  output logic wake_done_out,
  output logic lvr_enable_out,
  output logic [18:0] wdt_period_out,
  output logic cmp_enable_out,
  output logic [2:0] cmp_minus_sel_out,
  output logic cmp_minus_reserved_out,
  output logic cmp_plus_sel_out,
  output logic cmp_result_out
);

  // Registers and their next values
  wwc_wake_cfg_s wake_cfg_reg;
  wwc_wake_cfg_s wake_cfg_next;
  wwc_cmp_cfg_s cmp_cfg_reg;
  wwc_cmp_cfg_s cmp_cfg_next;
  wwc_wake_state_e wake_state_reg;
  wwc_wake_state_e wake_state_next;
  logic [11:0] tick_cnt_reg;
  logic [11:0] tick_cnt_next;
  logic [11:0] wake_target_reg;
  logic [11:0] wake_target_next;
  logic stab_needed_reg;
  logic stab_needed_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic sampled_reg;
  logic sampled_next;
  logic result_reg;
  logic result_next;
  logic [18:0] wdt_period_reg;
  logic [18:0] wdt_period_next;
  logic busy_reg;
  logic done_reg;
  logic lvr_en_reg;
  logic minus_rsv_reg;

  // Synchronised external levels and edges
  logic ls_level;
  logic ls_tick;
  logic tm2_level;
  logic tm2_rise;
  logic cmp_level;

  wwc_sync_edge u_ls_sync (
    .mclk_in(mclk_in),
    .reset_n_in(reset_n_in),
    .async_in(low_speed_internal_osc_in),
    .level_out(ls_level),
    .rise_out(ls_tick)
  );

  wwc_sync_edge u_tm2_sync (
    .mclk_in(mclk_in),
    .reset_n_in(reset_n_in),
    .async_in(timer_two_clock_in),
    .level_out(tm2_level),
    .rise_out(tm2_rise)
  );

  wwc_sync_edge u_cmp_sync (
    .mclk_in(mclk_in),
    .reset_n_in(reset_n_in),
    .async_in(cmp_raw_in),
    .level_out(cmp_level),
    .rise_out()
  );

  // Register decode
  // Reads of the write-only register and of unmapped addresses return zero
  wire sel_wake = (io_addr_in == WWC_ADDR_WAKE_WDT);
  wire sel_cmp = (io_addr_in == WWC_ADDR_CMP_CTRL);
  wire wr_wake = io_wr_in & sel_wake;
  wire wr_cmp = io_wr_in & sel_cmp;
  wire rd_cmp = io_rd_in & sel_cmp;

  // Reserved bits 7-6 and 4-3 are not stored, so stray ones have no effect
  always_comb begin
    wake_cfg_next = wake_cfg_reg;
    if (wr_wake) begin
      wake_cfg_next.fast_wake = io_wdata_in[WWC_FAST_WAKE_BIT];
      wake_cfg_next.lvr_disable = io_wdata_in[WWC_LVR_DIS_BIT];
      wake_cfg_next.wdt_sel = io_wdata_in[WWC_WDT_SEL_MSB:WWC_WDT_SEL_LSB];
    end
  end

  // Bit 6 of a write is ignored: it is the read-only result
  always_comb begin
    cmp_cfg_next = cmp_cfg_reg;
    if (wr_cmp) begin
      cmp_cfg_next.enable = io_wdata_in[WWC_CMP_EN_BIT];
      cmp_cfg_next.sample = io_wdata_in[WWC_CMP_SAMPLE_BIT];
      cmp_cfg_next.invert = io_wdata_in[WWC_CMP_INV_BIT];
      cmp_cfg_next.minus_sel = io_wdata_in[WWC_CMP_MINUS_MSB:WWC_CMP_MINUS_LSB];
      cmp_cfg_next.plus_sel = io_wdata_in[WWC_CMP_PLUS_BIT];
    end
  end

  // Comparison result reads low while the comparator is off; with bit 5 clear the result output then equals the invert bit
  wire cmp_true = cmp_level & cmp_cfg_reg.enable;
  wire cmp_polar = cmp_true ^ cmp_cfg_reg.invert;

  always_comb begin
    rdata_next = WWC_READ_NONE;
    if (rd_cmp) begin
      rdata_next[WWC_CMP_EN_BIT] = cmp_cfg_reg.enable;
      rdata_next[WWC_CMP_RES_BIT] = cmp_true;
      rdata_next[WWC_CMP_SAMPLE_BIT] = cmp_cfg_reg.sample;
      rdata_next[WWC_CMP_INV_BIT] = cmp_cfg_reg.invert;
      rdata_next[WWC_CMP_MINUS_MSB:WWC_CMP_MINUS_LSB] = cmp_cfg_reg.minus_sel;
      rdata_next[WWC_CMP_PLUS_BIT] = cmp_cfg_reg.plus_sel;
    end
  end

  // Sampling tracks the synchronised timer-2 clock, so it lags the pin by two cycles
  assign sampled_next = tm2_rise ? cmp_polar : sampled_reg;
  assign result_next = cmp_cfg_reg.sample ? sampled_reg : cmp_polar;

  // Watchdog period selection
  always_comb begin
    unique case (wake_cfg_reg.wdt_sel)
      WWC_WDT_8K: wdt_period_next = WWC_WDT_PERIOD_8K;
      WWC_WDT_16K: wdt_period_next = WWC_WDT_PERIOD_16K;
      WWC_WDT_64K: wdt_period_next = WWC_WDT_PERIOD_64K;
      WWC_WDT_256K: wdt_period_next = WWC_WDT_PERIOD_256K;
    endcase
  end

  // Fast wake is honoured only without the external oscillator
  wire fast_eff = wake_cfg_reg.fast_wake & ~external_oscillator_en_in;
  wire [11:0] start_target = fast_eff ? WWC_WAKE_FAST_TICKS : WWC_WAKE_NORMAL_TICKS;
  wire start_stab = fast_eff & wake_from_system_stop_in;
  // The count ends on the tick that reaches the target, so N ticks take N edges
  wire tick_last = ls_tick & (tick_cnt_reg == wake_target_reg - WWC_TICK_ONE);
  wire wake_accept = wake_request_in & (wake_state_reg == WWC_WAKE_IDLE);

  // Wake-up sequencer counting low-speed oscillator edges
  always_comb begin
    wake_state_next = wake_state_reg;
    tick_cnt_next = tick_cnt_reg;
    wake_target_next = wake_target_reg;
    stab_needed_next = stab_needed_reg;
    unique case (wake_state_reg)
      WWC_WAKE_IDLE: begin
        // Captured here so later register writes cannot stretch or cut a running wake
        if (wake_accept) begin
          wake_state_next = WWC_WAKE_COUNT;
          tick_cnt_next = WWC_TICK_ZERO;
          wake_target_next = start_target;
          stab_needed_next = start_stab;
        end
      end
      WWC_WAKE_COUNT: begin
        if (tick_last) begin
          tick_cnt_next = WWC_TICK_ZERO;
          if (stab_needed_reg) begin
            wake_state_next = WWC_WAKE_STAB;
            wake_target_next = OSC_STABLE_TICKS;
          end else begin
            wake_state_next = WWC_WAKE_DONE;
          end
        end else if (ls_tick) begin
          tick_cnt_next = tick_cnt_reg + WWC_TICK_ONE;
        end
      end
      WWC_WAKE_STAB: begin
        if (tick_last) begin
          wake_state_next = WWC_WAKE_DONE;
          tick_cnt_next = WWC_TICK_ZERO;
        end else if (ls_tick) begin
          tick_cnt_next = tick_cnt_reg + WWC_TICK_ONE;
        end
      end
      WWC_WAKE_DONE: begin
        wake_state_next = WWC_WAKE_IDLE;
      end
    endcase
  end

  // Status next values; every output is registered so none glitches
  // Reserved minus codes are stored as written and only flagged
  wire busy_next = (wake_state_next != WWC_WAKE_IDLE);
  wire done_next = (wake_state_next == WWC_WAKE_DONE);
  wire lvr_en_next = ~wake_cfg_next.lvr_disable;
  wire minus_rsv_next = (cmp_cfg_next.minus_sel > WWC_MINUS_PORT_B_PIN_SEVEN);

  // Register contents
  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      wake_cfg_reg <= wwc_wake_cfg_s'(WWC_REG_RESET[$bits(wwc_wake_cfg_s)-1:0]);
      cmp_cfg_reg <= wwc_cmp_cfg_s'(WWC_REG_RESET[$bits(wwc_cmp_cfg_s)-1:0]);
    end else begin
      wake_cfg_reg <= wake_cfg_next;
      cmp_cfg_reg <= cmp_cfg_next;
    end
  end

  // Read data stands for one cycle after the read strobe
  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      rdata_reg <= WWC_REG_RESET;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      wake_state_reg <= WWC_WAKE_IDLE;
      tick_cnt_reg <= WWC_TICK_ZERO;
      wake_target_reg <= WWC_WAKE_NORMAL_TICKS;
      stab_needed_reg <= 1'b0;
    end else begin
      wake_state_reg <= wake_state_next;
      tick_cnt_reg <= tick_cnt_next;
      wake_target_reg <= wake_target_next;
      stab_needed_reg <= stab_needed_next;
    end
  end

  // Comparator output path, registered in both modes
  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      sampled_reg <= 1'b0;
      result_reg <= 1'b0;
    end else begin
      sampled_reg <= sampled_next;
      result_reg <= result_next;
    end
  end

  // Status outputs
  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      wdt_period_reg <= WWC_WDT_PERIOD_8K;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      lvr_en_reg <= ~WWC_REG_RESET[WWC_LVR_DIS_BIT];
      minus_rsv_reg <= 1'b0;
    end else begin
      wdt_period_reg <= wdt_period_next;
      busy_reg <= busy_next;
      done_reg <= done_next;
      lvr_en_reg <= lvr_en_next;
      minus_rsv_reg <= minus_rsv_next;
    end
  end

  // Outputs straight from flops
  assign io_rdata_out = rdata_reg;
  assign wake_busy_out = busy_reg;
  assign wake_done_out = done_reg;
  assign lvr_enable_out = lvr_en_reg;
  assign wdt_period_out = wdt_period_reg;
  assign cmp_enable_out = cmp_cfg_reg.enable;
  assign cmp_minus_sel_out = cmp_cfg_reg.minus_sel;
  assign cmp_minus_reserved_out = minus_rsv_reg;
  assign cmp_plus_sel_out = cmp_cfg_reg.plus_sel;
  assign cmp_result_out = result_reg;

  // Level of the low-speed and timer-2 clocks is not needed beyond their edges
  wire unused_levels = ls_level ^ tm2_level;

endmodule
`default_nettype wire

/* verilog/wwc_sync_edge.sv */
// Two-flop synchroniser with a rising-edge pulse on the mclk_in domain.
// Assumes async_in is a level from another clock or a pin.
`timescale 1ns/100ps
`default_nettype none
module wwc_sync_edge (
  input wire logic mclk_in,
  input wire logic reset_n_in,
  input wire logic async_in,
  output logic level_out,
  output logic rise_out
);
  logic meta_reg;
  logic sync_reg;
  logic last_reg;

  // Edge taken from second and third flops only, never the metastable first
  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      last_reg <= 1'b0;
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  assign level_out = sync_reg;
  assign rise_out = sync_reg & ~last_reg;
endmodule
`default_nettype wire
